// File: can_rx_pkg.sv
// shared constants and types for the receive buffer router
package can_rx_pkg;

    // ------------------------------------------------------------
    // message shape
    // ------------------------------------------------------------
    localparam int ID_W      = 29;
    localparam int STD_W     = 11;
    localparam int MSG_BYTES = 13;
    localparam int FILTERS   = 6;
    localparam int PRI_FILTS = 2;
    localparam int BYTE_W    = 8;
    localparam int FIFO_D    = 32;

    localparam logic [3:0] LAST_BYTE = 4'hC;
    localparam logic [3:0] IDX_ZERO  = 4'h0;
    localparam logic [3:0] IDX_ONE   = 4'h1;

    // standard identifiers sit in the top eleven identifier bits
    localparam logic [ID_W-1:0] STD_CARE =
        {{STD_W{1'b1}}, {(ID_W-STD_W){1'b0}}};

    // ------------------------------------------------------------
    // receive modes and codes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_ALL = 2'h3;

    localparam logic [2:0] HIT_F0 = 3'h0;
    localparam logic [2:0] HIT_F1 = 3'h1;

    localparam logic [3:0] STAT_NONE      = 4'h0;
    localparam logic [3:0] STAT_PRIMARY   = 4'hC;
    localparam logic [3:0] STAT_SECONDARY = 4'hE;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MOVE = 2'b01,
        ST_DONE = 2'b11
    } move_state_t;

endpackage

// File: id_filter_match.sv
// one acceptance filter compared against a received identifier
`timescale 1ns/10ps
module id_filter_match
    import can_rx_pkg::*;
#(
    parameter int W = ID_W
) (
    // filter setup
    input  wire logic [W-1:0] mask,
    input  wire logic [W-1:0] filt,
    input  wire logic         filt_ext,
    // message under test
    input  wire logic [W-1:0] msg_id,
    input  wire logic         msg_ext,
    // result
    output      logic         hit
);
    logic [W-1:0] care;

    always_comb begin
        care = msg_ext ? {W{1'b1}} : STD_CARE[W-1:0];
        hit  = (filt_ext == msg_ext) &&
               ((((filt ^ msg_id) & mask) & care) == '0);
    end
endmodule

// File: byte_fifo.sv
// first-in first-out buffer with valid/ready on both sides
`timescale 1ns/10ps
module byte_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // fill side
    input  wire logic         in_valid,
    output      logic         in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output      logic         out_valid,
    input  wire logic         out_ready,
    output      logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [AW:0] wptr;
        logic [AW:0] rptr;
    } fifo_state_t;

    fifo_state_t  cur;
    fifo_state_t  next_cur;
    logic [W-1:0] mem [D];
    logic         push;

    always_comb begin
        out_valid = cur.wptr != cur.rptr;
        in_ready  = (cur.wptr[AW-1:0] != cur.rptr[AW-1:0]) ||
                    (cur.wptr[AW] == cur.rptr[AW]);
        out_data  = mem[cur.rptr[AW-1:0]];
        push      = in_valid && in_ready;
        next_cur  = cur;
        if (push) begin
            next_cur.wptr = cur.wptr + 1'b1;
        end
        if (out_valid && out_ready) begin
            next_cur.rptr = cur.rptr + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[cur.wptr[AW-1:0]] <= in_data;
        end
    end
endmodule

// File: can_receive_buffer_router.sv
// receive buffer routing, flags, buffer-full pins and start-of-frame
`timescale 1ns/10ps
module can_receive_buffer_router
    import can_rx_pkg::*;
(
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          rst,
    // assembly buffer bytes from the protocol engine
    input  wire logic                          asm_valid,
    output      logic                          asm_ready,
    input  wire logic [BYTE_W-1:0]             asm_data,
    // end of assembled frame
    input  wire logic                          frame_end,
    output      logic                          frame_ready,
    input  wire logic [ID_W-1:0]               msg_id,
    input  wire logic                          msg_ext,
    input  wire logic                          msg_rtr,
    input  wire logic                          frame_err,
    input  wire logic [3:0]                    frame_len,
    // masks, filters and buffer setup
    input  wire logic [ID_W-1:0]               mask_primary,
    input  wire logic [ID_W-1:0]               mask_secondary,
    input  wire logic [FILTERS-1:0][ID_W-1:0]  filter_id,
    input  wire logic [FILTERS-1:0]            extended_id_select,
    input  wire logic [1:0]                    rx_mode_primary,
    input  wire logic [1:0]                    rx_mode_secondary,
    input  wire logic                          rollover_enable,
    // flag control from the host
    input  wire logic [1:0]                    rx_irq_enable,
    input  wire logic [1:0]                    clr_full,
    input  wire logic [1:0]                    clr_overflow,
    // host read of the receive buffers
    input  wire logic                          rd_sel,
    input  wire logic [3:0]                    rd_idx,
    output      logic [BYTE_W-1:0]             rd_data,
    // status
    output      logic [1:0]                    rx_full_flag,
    output      logic                          primary_overflow_flag,
    output      logic                          secondary_overflow_flag,
    output      logic [3:0]                    primary_ctrl_low,
    output      logic [3:0]                    secondary_ctrl_low,
    output      logic [3:0]                    controller_status_low,
    output      logic                          irq_n,
    // buffer full pins
    input  wire logic [1:0]                    pin_function_enable,
    input  wire logic [1:0]                    pin_irq_mode,
    input  wire logic [1:0]                    pin_output_level,
    output      logic [1:0]                    buffer_full_pin_out,
    output      logic [1:0]                    buffer_full_pin_oe_n,
    // start of frame
    input  wire logic                          bus_rx_line,
    input  wire logic                          bus_idle,
    input  wire logic                          sample_tick,
    input  wire logic                          sof_enable,
    output      logic                          sof_pulse
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        move_state_t       st;
        logic [3:0]        idx;
        logic [3:0]        len;
        logic              load;
        logic              sel;
        logic [2:0]        code;
        logic              rtr;
        logic [1:0]        full;
        logic [1:0]        ovr;
        logic              hit0;
        logic [2:0]        hit1;
        logic [1:0]        rtr_flag;
        logic [3:0]        stat;
        logic [BYTE_W-1:0] rd_data;
        logic              rx_s1;
        logic              rx_s2;
        logic              rx_s3;
        logic              sof_armed;
        logic              sof_pulse;
    } router_state_t;

    router_state_t     cur;
    router_state_t     next_cur;
    logic [BYTE_W-1:0] mem [2][MSG_BYTES];

    logic [FILTERS-1:0] hits;
    logic               fifo_valid;
    logic               fifo_ready;
    logic [BYTE_W-1:0]  fifo_data;
    logic               take;
    logic               acc0;
    logic               acc1;
    logic [2:0]         code0;
    logic [2:0]         code1;
    logic [1:0]         set_full;
    logic [1:0]         set_ovr;
    logic               need_byte;
    logic               wr_en;
    logic [BYTE_W-1:0]  wr_data;
    logic               fall;

    // ------------------------------------------------------------
    // assembly byte buffer
    // ------------------------------------------------------------
    // the drain side only pops while moving a frame, so the engine
    // sees back-pressure on asm_ready only once the FIFO_D-deep buffer fills
    byte_fifo #(
        .W (BYTE_W),
        .D (FIFO_D)
    ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (asm_valid),
        .in_ready  (asm_ready),
        .in_data   (asm_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data)
    );

    // ------------------------------------------------------------
    // acceptance filters
    // ------------------------------------------------------------
    for (genvar i = 0; i < FILTERS; i++) begin : g_filt
        id_filter_match #(
            .W (ID_W)
        ) u_match (
            .mask     ((i < PRI_FILTS) ? mask_primary : mask_secondary),
            .filt     (filter_id[i]),
            .filt_ext (extended_id_select[i]),
            .msg_id   (msg_id),
            .msg_ext  (msg_ext),
            .hit      (hits[i])
        );
    end

    // ------------------------------------------------------------
    // routing decision
    // ------------------------------------------------------------
    always_comb begin
        code0 = hits[0] ? HIT_F0 : HIT_F1;
        // descending scan: the lowest set filter is written last
        code1 = 3'h2;
        for (int k = FILTERS - 1; k >= PRI_FILTS; k--) begin
            if (hits[k]) begin
                code1 = 3'(k);
            end
        end
        // modes 01 and 10 fall back to plain filtering
        acc0 = (rx_mode_primary == MODE_ALL) ||
               (!frame_err && (|hits[PRI_FILTS-1:0]));
        acc1 = (rx_mode_secondary == MODE_ALL) ||
               (!frame_err && (|hits[FILTERS-1:PRI_FILTS]));
    end

    // ------------------------------------------------------------
    // sequencing and flags
    // ------------------------------------------------------------
    always_comb begin
        next_cur   = cur;
        take       = frame_end && (cur.st == ST_IDLE);
        set_full   = 2'h0;
        set_ovr    = 2'h0;
        need_byte  = cur.idx < cur.len;
        fifo_ready = (cur.st == ST_MOVE) && need_byte;
        wr_en      = (cur.st == ST_MOVE) && cur.load &&
                     (!need_byte || fifo_valid);
        wr_data    = need_byte ? fifo_data : '0;
        fall       = cur.rx_s3 && !cur.rx_s2;

        case (cur.st)
            ST_IDLE: begin
                if (take) begin
                    next_cur.st   = ST_MOVE;
                    next_cur.idx  = IDX_ZERO;
                    next_cur.len  = (frame_len > LAST_BYTE) ?
                                    LAST_BYTE + IDX_ONE : frame_len;
                    next_cur.rtr  = msg_rtr;
                    next_cur.load = 1'b0;
                    // primary is tried first, then secondary
                    if (acc0) begin
                        if (!cur.full[0]) begin
                            next_cur.load = 1'b1;
                            next_cur.sel  = 1'b0;
                            next_cur.code = code0;
                        end else if (rollover_enable) begin
                            if (!cur.full[1]) begin
                                next_cur.load = 1'b1;
                                next_cur.sel  = 1'b1;
                                next_cur.code = code0;
                            end else begin
                                set_ovr[1] = 1'b1;
                            end
                        end else begin
                            set_ovr[0] = 1'b1;
                        end
                    end else if (acc1) begin
                        if (!cur.full[1]) begin
                            next_cur.load = 1'b1;
                            next_cur.sel  = 1'b1;
                            next_cur.code = code1;
                        end else begin
                            set_ovr[1] = 1'b1;
                        end
                    end
                end
            end
            ST_MOVE: begin
                // rejected frames are still drained, just not stored
                if (!need_byte || fifo_valid) begin
                    next_cur.idx = cur.idx + IDX_ONE;
                    if (cur.idx == LAST_BYTE) begin
                        next_cur.st = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                next_cur.st = ST_IDLE;
                if (cur.load) begin
                    set_full[cur.sel] = 1'b1;
                    if (cur.sel) begin
                        next_cur.hit1        = cur.code;
                        next_cur.rtr_flag[1] = cur.rtr;
                        next_cur.stat        = STAT_SECONDARY;
                    end else begin
                        next_cur.hit0        = cur.code[0];
                        next_cur.rtr_flag[0] = cur.rtr;
                        next_cur.stat        = STAT_PRIMARY;
                    end
                end
            end
            default: begin
                next_cur.st = ST_IDLE;
            end
        endcase

        // a set in the same cycle as the host's clear wins
        next_cur.full = (cur.full & ~clr_full) | set_full;
        next_cur.ovr  = (cur.ovr & ~clr_overflow) | set_ovr;

        next_cur.rd_data = (rd_idx <= LAST_BYTE) ?
                           mem[rd_sel][rd_idx] : '0;

        // start of frame: glitches shorter than the sample point drop
        next_cur.rx_s1     = bus_rx_line;
        next_cur.rx_s2     = cur.rx_s1;
        next_cur.rx_s3     = cur.rx_s2;
        next_cur.sof_pulse = cur.sof_armed && sample_tick &&
                             !cur.rx_s2;
        if (sof_enable && bus_idle && fall) begin
            next_cur.sof_armed = 1'b1;
        end else if (cur.sof_armed && (cur.rx_s2 || sample_tick)) begin
            next_cur.sof_armed = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cur       <= '0;
            cur.st    <= ST_IDLE;
            cur.stat  <= STAT_NONE;
            cur.rx_s1 <= 1'b1;
            cur.rx_s2 <= 1'b1;
            cur.rx_s3 <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[cur.sel][cur.idx] <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        frame_ready             = cur.st == ST_IDLE;
        rd_data                 = cur.rd_data;
        rx_full_flag            = cur.full;
        primary_overflow_flag   = cur.ovr[0];
        secondary_overflow_flag = cur.ovr[1];
        primary_ctrl_low        = {cur.rtr_flag[0], rollover_enable,
                                   rollover_enable, cur.hit0};
        secondary_ctrl_low      = {cur.rtr_flag[1], cur.hit1};
        controller_status_low   = cur.stat;
        irq_n                   = ~|(cur.full & rx_irq_enable);
        sof_pulse               = cur.sof_pulse;
        for (int b = 0; b < 2; b++) begin
            buffer_full_pin_oe_n[b] = !pin_function_enable[b];
            buffer_full_pin_out[b]  = pin_irq_mode[b] ?
                                      !cur.full[b] :
                                      pin_output_level[b];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_load_done;
        cur.st == ST_DONE && cur.load;
    endsequence

    property p_full_set;
        s_load_done |=> cur.full[$past(cur.sel)];
    endproperty
    a_full_set: assert property (p_full_set)
        else $error("loaded buffer did not raise its full flag");

    property p_no_load_full;
        take && next_cur.load |-> !cur.full[next_cur.sel];
    endproperty
    a_no_load_full: assert property (p_no_load_full)
        else $error("message routed into a buffer still full");

    property p_irq;
        (cur.full & rx_irq_enable) != 2'h0 |-> !irq_n;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output not low for enabled full flag");

    property p_primary_first;
        take && acc0 && !cur.full[0] |=> cur.load && !cur.sel;
    endproperty
    a_primary_first: assert property (p_primary_first)
        else $error("primary-accepted message not sent to primary");

    property p_rollover;
        take && acc0 && cur.full[0] && rollover_enable && !cur.full[1]
        |=> cur.load && cur.sel && !$rose(cur.ovr[0]);
    endproperty
    a_rollover: assert property (p_rollover)
        else $error("rollover did not move the message to secondary");

    property p_overflow;
        take && acc0 && cur.full[0] && !rollover_enable
        |=> cur.ovr[0] && !cur.load;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("primary overflow not flagged on full buffer");

    property p_pin_hiz;
        !pin_function_enable[0] |-> buffer_full_pin_oe_n[0];
    endproperty
    a_pin_hiz: assert property (p_pin_hiz)
        else $error("disabled full pin is being driven");

    property p_pin_irq;
        pin_function_enable[1] && pin_irq_mode[1] && cur.full[1]
        |-> !buffer_full_pin_oe_n[1] && !buffer_full_pin_out[1];
    endproperty
    a_pin_irq: assert property (p_pin_irq)
        else $error("full pin not driven low in interrupt mode");

    sequence s_sof_edge;
        sof_enable && bus_idle && cur.rx_s3 && !cur.rx_s2;
    endsequence

    property p_sof;
        s_sof_edge ##1 (sample_tick && !cur.rx_s2) |=> sof_pulse;
    endproperty
    a_sof: assert property (p_sof)
        else $error("held dominant edge produced no start pulse");

    property p_glitch;
        cur.sof_armed && cur.rx_s2 |=> !sof_pulse;
    endproperty
    a_glitch: assert property (p_glitch)
        else $error("glitch produced a start pulse");

    property p_move_len;
        cur.st == ST_IDLE && take |=> cur.st == ST_MOVE ##[13:300]
            cur.st == ST_DONE;
    endproperty
    a_move_len: assert property (p_move_len)
        else $error("frame move did not cover all buffer bytes");

endmodule

// File: can_engine_model.sv
// protocol engine model that feeds assembled frames to the router
`timescale 1ns/10ps
module can_engine_model (
    // clock
    input  wire logic        mclk,
    // handshakes from the router
    input  wire logic        asm_ready,
    input  wire logic        frame_ready,
    // assembly bytes
    output      logic        asm_valid,
    output      logic [7:0]  asm_data,
    // frame end and its qualifiers
    output      logic        frame_end,
    output      logic [28:0] msg_id,
    output      logic        msg_ext,
    output      logic        msg_rtr,
    output      logic        frame_err,
    output      logic [3:0]  frame_len
);
    initial begin
        {asm_valid, asm_data, frame_end, msg_id} = '0;
        {msg_ext, msg_rtr, frame_err, frame_len} = '0;
    end
    // a byte stays offered until the router takes it at an edge
    task automatic push(input int n);
        for (int k = 0; k < n; k++) begin
            asm_valid = 1'b1;
            asm_data  = 8'h10 + 8'(k);
            do @(posedge mclk); while (asm_ready !== 1'b1);
            #1;
        end
        asm_valid = 1'b0;
        asm_data  = ~asm_data;
    endtask
    task automatic send(input logic [28:0] id, input logic [2:0] f,
                        input logic [3:0] n);
        {msg_ext, msg_rtr, frame_err} = f;
        msg_id    = id;
        frame_len = n;
        frame_end = 1'b1;
        do @(posedge mclk); while (frame_ready !== 1'b1);
        #1 frame_end = 1'b0;
        msg_id = ~id;
    endtask
    // offer bytes with nobody draining; counts what was accepted
    task automatic fill(output int c);
        c = 0;
        asm_valid = 1'b1;
        repeat (40) begin
            @(posedge mclk);
            if (asm_ready === 1'b1) begin
                c++;
                #1 asm_data = asm_data + 8'h01;
            end
        end
        #1 asm_valid = 1'b0;
    endtask
endmodule

// File: can_receive_buffer_router_bench.sv
// self-checking bench for the receive buffer router
`timescale 1ns/10ps
module can_receive_buffer_router_bench;
    import can_rx_pkg::*;
    logic mclk, rst, asm_valid, asm_ready, frame_end, frame_ready;
    logic msg_ext, msg_rtr, frame_err, rollover_enable, rd_sel, irq_n;
    logic primary_overflow_flag, secondary_overflow_flag;
    logic bus_rx_line, bus_idle, sample_tick, sof_enable, sof_pulse;
    logic [7:0] asm_data, rd_data, hits;
    logic [3:0] frame_len, rd_idx, primary_ctrl_low, secondary_ctrl_low;
    logic [3:0] controller_status_low;
    logic [ID_W-1:0] msg_id, mask_primary, mask_secondary;
    logic [FILTERS-1:0][ID_W-1:0] filter_id;
    logic [FILTERS-1:0] extended_id_select;
    logic [1:0] rx_mode_primary, rx_mode_secondary, rx_irq_enable;
    logic [1:0] clr_full, clr_overflow, rx_full_flag, pin_function_enable;
    logic [1:0] pin_irq_mode, pin_output_level, buffer_full_pin_out;
    logic [1:0] buffer_full_pin_oe_n;
    int n_mismatch = 0, compares = 0, cnt;
    can_receive_buffer_router dut_u (.mclk, .rst, .asm_valid, .asm_ready,
        .asm_data, .frame_end, .frame_ready, .msg_id, .msg_ext, .msg_rtr,
        .frame_err, .frame_len, .mask_primary, .mask_secondary, .filter_id,
        .extended_id_select, .rx_mode_primary, .rx_mode_secondary,
        .rollover_enable, .rx_irq_enable, .clr_full, .clr_overflow, .rd_sel,
        .rd_idx, .rd_data, .rx_full_flag, .primary_overflow_flag,
        .secondary_overflow_flag, .primary_ctrl_low, .secondary_ctrl_low,
        .controller_status_low, .irq_n, .pin_function_enable, .pin_irq_mode,
        .pin_output_level, .buffer_full_pin_out, .buffer_full_pin_oe_n,
        .bus_rx_line, .bus_idle, .sample_tick, .sof_enable, .sof_pulse);
    can_engine_model eng_u (.mclk, .asm_ready, .frame_ready, .asm_valid,
        .asm_data, .frame_end, .msg_id, .msg_ext, .msg_rtr, .frame_err,
        .frame_len);
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    function automatic logic [ID_W-1:0] sid(input logic [10:0] s);
        return {s, 18'h0};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic frame(input logic [10:0] s, input logic [2:0] f,
                         input logic [3:0] n);
        eng_u.push(n);
        eng_u.send(sid(s), f, n);
    endtask
    task automatic wait_flag(input int b);
        repeat (40) if (rx_full_flag[b] !== 1'b1) @(posedge mclk) #1;
    endtask
    task automatic rdchk(input logic s, input logic [3:0] i,
                         input logic [7:0] e);
        rd_sel = s;
        rd_idx = i;
        @(posedge mclk) #1 chk("rd_data", rd_data, e);
    endtask
    task automatic clear(input logic [1:0] f, input logic [1:0] o);
        clr_full     = f;
        clr_overflow = o;
        @(posedge mclk) #1 {clr_full, clr_overflow} = '0;
        @(posedge mclk) #1;
    endtask
    task automatic print_verdict;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #400000;
        n_mismatch++;
        print_verdict;
    end
    initial begin
        rst = 1'b1;
        {mask_primary, mask_secondary} = '1;
        filter_id = {sid(6), sid(3), sid(4), sid(3), sid(2), sid(1)};
        {extended_id_select, rx_mode_primary, rx_mode_secondary} = '0;
        {rollover_enable, clr_full, clr_overflow, rd_sel, rd_idx} = '0;
        {sample_tick, sof_enable, pin_output_level} = '0;
        {rx_irq_enable, pin_function_enable, pin_irq_mode} = '1;
        {bus_rx_line, bus_idle} = 2'b11;
        repeat (10) @(posedge mclk);
        #1 rst = 1'b0;
        chk("irq_n", irq_n, 1);
        frame(11'd1, 3'b000, 4'd8);
        chk("frame_ready", frame_ready, 0);
        wait_flag(0);
        chk("full", rx_full_flag, 2'b01);
        chk("ctrl0", primary_ctrl_low, 4'h0);
        chk("stat", controller_status_low, STAT_PRIMARY);
        chk("irq_n", irq_n, 0);
        chk("pins", {buffer_full_pin_oe_n, buffer_full_pin_out}, 2);
        for (int k = 0; k < MSG_BYTES; k++)
            rdchk(0, 4'(k), k < 8 ? 8'h10 + 8'(k) : 8'h00);
        $display("test primary load done");
        rollover_enable = 1'b1;
        frame(11'd2, 3'b010, 4'd2);
        wait_flag(1);
        chk("ctrl1", secondary_ctrl_low, {1'b1, HIT_F1});
        chk("ovf", primary_overflow_flag, 0);
        chk("stat", controller_status_low, STAT_SECONDARY);
        frame(11'd1, 3'b000, 4'd4);
        repeat (2) @(posedge mclk) #1;
        chk("ovf", {primary_overflow_flag, secondary_overflow_flag}, 1);
        rollover_enable = 1'b0;
        frame(11'd1, 3'b000, 4'd4);
        repeat (2) @(posedge mclk) #1;
        chk("ovf", {primary_overflow_flag, secondary_overflow_flag}, 3);
        rdchk(0, 4'd7, 8'h17);
        clear(2'b11, 2'b11);
        chk("flags", {rx_full_flag, primary_overflow_flag,
            secondary_overflow_flag, irq_n}, 5'b00001);
        chk("pins", {buffer_full_pin_oe_n, buffer_full_pin_out}, 3);
        $display("test rollover and overflow done");
        frame(11'd3, 3'b000, 4'd1);
        wait_flag(1);
        chk("ctrl1", secondary_ctrl_low, 4'h2);
        clear(2'b10, 2'b00);
        rx_mode_secondary = MODE_ALL;
        frame(11'd9, 3'b001, 4'd3);
        wait_flag(1);
        chk("ctrl1", secondary_ctrl_low, 4'h2);
        rdchk(1, 4'd2, 8'h12);
        rdchk(1, 4'd3, 8'h00);
        clear(2'b10, 2'b00);
        rx_mode_secondary = 2'b00;
        frame(11'd1, 3'b100, 4'd1);
        repeat (20) @(posedge mclk) #1;
        chk("full", rx_full_flag, 0);
        rx_mode_primary = MODE_ALL;
        frame(11'd9, 3'b100, 4'd1);
        wait_flag(0);
        chk("stat", controller_status_low, STAT_PRIMARY);
        $display("test filters and modes done");
        pin_irq_mode = 2'b00;
        for (int c = 0; c < 4; c++) begin
            pin_function_enable = {2{c[1]}};
            pin_output_level    = c[0] ? 2'b01 : 2'b10;
            #1 chk("pins", {buffer_full_pin_oe_n, buffer_full_pin_out},
                {c[1] ? 2'b00 : 2'b11, pin_output_level});
        end
        $display("test pin modes done");
        sof_enable = 1'b1;
        for (int g = 0; g < 2; g++) begin
            bus_rx_line = 1'b0;
            if (g == 1) @(posedge mclk) #1 bus_rx_line = 1'b1;
            repeat (6) @(posedge mclk);
            #1 sample_tick = 1'b1;
            @(posedge mclk) #1 sample_tick = 1'b0;
            hits = 8'h00;
            repeat (4) begin
                hits = hits + 8'(sof_pulse);
                @(posedge mclk) #1;
            end
            chk("sof", hits, g == 1 ? 0 : 1);
            bus_rx_line = 1'b1;
            repeat (6) @(posedge mclk) #1;
        end
        $display("test start of frame done");
        eng_u.fill(cnt);
        chk("fill", cnt, FIFO_D);
        chk("ready", asm_ready, 0);
        eng_u.send(sid(11'd9), 3'b000, 4'd13);
        repeat (20) @(posedge mclk) #1;
        chk("ready", asm_ready, 1);
        $display("test buffer fill done");
        print_verdict;
    end
endmodule
